// ---- hw/sdbs_pkg.sv ----
// shared constants for the slope delta bit sequencer
package sdbs_pkg;
    localparam int HIST_W = 3;                  // length of the bit history register
    localparam logic [1:0] FILL_FULL = 2'h3;    // shifts needed before history is known
    localparam logic [1:0] FILL_RST = 2'h0;     // fill count after reset
    localparam logic [2:0] HIST_RST = 3'h0;     // history value after reset
    localparam logic BIT_RST = 1'b0;            // serial output and slope after reset
    localparam int FIFO_W = 1;                  // width of one captured stream word
    localparam int FIFO_D = 4;                  // depth of the capture fifo
    localparam int BIT_RATE_HZ = 16000;         // nominal serial bit rate
    localparam int MCLK_HZ = 100000000;         // core clock rate
    localparam int BIT_PERIOD_CYC = MCLK_HZ / BIT_RATE_HZ; // core cycles per bit
endpackage

// ---- hw/sdbs_stream_if.sv ----
// valid/ready stream carrier between the sequencer and its fifo
`timescale 1ns/1ps
interface sdbs_stream_if #(parameter int W = 1);
    logic valid;
    logic ready;
    logic [W-1:0] data;
    modport src (output valid, output data, input ready);
    modport snk (input valid, input data, output ready);
endinterface

// ---- hw/sdbs_fifo.sv ----
// small synchronous fifo with valid/ready on both sides
`timescale 1ns/1ps
module sdbs_fifo #(
    parameter int W = 1,
    parameter int D = 4
) (
    input wire logic mclk_i,
    input wire logic rst_n_i,
    sdbs_stream_if.snk in_s,
    sdbs_stream_if.src out_s
);
    localparam int AW = (D > 1) ? $clog2(D) : 1;
    localparam logic [AW:0] CNT_FULL = (AW+1)'(D);
    localparam logic [AW-1:0] PTR_LAST = AW'(D - 1);

    logic [W-1:0] mem [D];
    logic [AW-1:0] wr_q;
    logic [AW-1:0] rd_q;
    logic [AW:0] cnt_q;
    logic [AW:0] cnt_d;
    wire push;
    wire pop;
    wire full;
    wire empty;

    // status and handshake decode
    assign full = (cnt_q == CNT_FULL);
    assign empty = (cnt_q == '0);
    assign in_s.ready = ~full;
    assign out_s.valid = ~empty;
    assign out_s.data = mem[rd_q];
    assign push = in_s.valid & ~full;
    assign pop = out_s.ready & ~empty;
    assign cnt_d = cnt_q + (AW+1)'(push) - (AW+1)'(pop);

    // storage array, no reset needed on data
    always_ff @(posedge mclk_i)
    begin
        if (push)
        begin
            mem[wr_q] <= in_s.data;
        end
    end

    // pointers and occupancy
    always_ff @(posedge mclk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            wr_q <= '0;
            rd_q <= '0;
            cnt_q <= '0;
        end
        else
        begin
            if (push)
            begin
                wr_q <= (wr_q == PTR_LAST) ? '0 : wr_q + AW'(1);
            end
            if (pop)
            begin
                rd_q <= (rd_q == PTR_LAST) ? '0 : rd_q + AW'(1);
            end
            cnt_q <= cnt_d;
        end
    end
endmodule // sdbs_fifo

// ---- hw/sdbs_sequencer.sv ----
// slope delta bit sequencer: bit select, history, coincidence, serial out
`timescale 1ns/1ps
module sdbs_sequencer #(
    parameter int FIFO_W = sdbs_pkg::FIFO_W,
    parameter int FIFO_D = sdbs_pkg::FIFO_D
) (
    input wire logic mclk_i,
    input wire logic rst_n_i,
    input wire logic bit_clk_i,
    input wire logic encode_i,
    input wire logic ain_above_fb_i,
    input wire logic data_in_i,
    output logic data_out_o,
    output logic slope_source_o,
    output logic coinc_o,
    output logic coinc_oe_o,
    output logic [sdbs_pkg::HIST_W-1:0] hist_o,
    output logic hist_valid_o,
    output logic bit_strobe_o,
    output logic capture_ready_o,
    output logic [FIFO_W-1:0] stream_data_o,
    output logic stream_valid_o,
    input wire logic stream_ready_i
);
    localparam int HW = sdbs_pkg::HIST_W;

    // registers
    logic bit_clk_q;
    logic [HW-1:0] hist_q;
    logic [1:0] fill_q;
    logic out_q;
    logic slope_q;
    logic coinc_q;
    logic strobe_q;
    logic hist_valid_q;

    // next values and decode
    wire [HW-1:0] hist_d;
    logic [1:0] fill_d;
    wire fill_more;
    wire out_d;
    wire slope_d;
    wire fall;
    wire new_bit;
    wire all_same;
    wire hist_known_d;

    // carriers into and out of the capture fifo
    sdbs_stream_if #(.W(FIFO_W)) cap_s ();
    sdbs_stream_if #(.W(FIFO_W)) drn_s ();

    // true when every bit of a history word has the same value
    function automatic logic hist_uniform(input logic [HW-1:0] h);
        hist_uniform = (&h) | ~(|h);
    endfunction

    // falling edge of the bit clock, seen in the core clock
    assign fall = bit_clk_q & ~bit_clk_i;

    // bit selection: sign of comparison in encode, data level in decode
    assign new_bit = encode_i ? ain_above_fb_i : data_in_i;

    // next history: stage 0 takes the new bit, each later stage its neighbour
    assign hist_d[0] = fall ? new_bit : hist_q[0];
    generate
        for (genvar i = 1; i < HW; i++)
        begin : g_shift
            assign hist_d[i] = fall ? hist_q[i-1] : hist_q[i];
        end
    endgenerate

    // fill count saturates once the history holds only shifted bits
    assign fill_more = fall & (fill_q != sdbs_pkg::FILL_FULL);
    assign fill_d = fill_more ? fill_q + 2'h1 : fill_q;
    assign hist_known_d = (fill_d == sdbs_pkg::FILL_FULL);

    // coincidence of the next history, masked until it is known
    assign all_same = hist_uniform(hist_d) & hist_known_d;

    // next serial output and slope: output inverts the selected bit, slope follows it
    assign out_d = ~new_bit;
    assign slope_d = new_bit;

    // bit clock edge detector
    always_ff @(posedge mclk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            bit_clk_q <= 1'b0;
        end
        else
        begin
            bit_clk_q <= bit_clk_i;
        end
    end

    // history register
    always_ff @(posedge mclk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            hist_q <= sdbs_pkg::HIST_RST;
        end
        else
        begin
            hist_q <= hist_d;
        end
    end

    // fill count of shifted bits
    always_ff @(posedge mclk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            fill_q <= sdbs_pkg::FILL_RST;
        end
        else
        begin
            fill_q <= fill_d;
        end
    end

    // serial output, updated only at the falling edge
    always_ff @(posedge mclk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            out_q <= sdbs_pkg::BIT_RST;
        end
        else if (fall)
        begin
            out_q <= out_d;
        end
    end

    // slope polarity, updated only at the falling edge
    always_ff @(posedge mclk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            slope_q <= sdbs_pkg::BIT_RST;
        end
        else if (fall)
        begin
            slope_q <= slope_d;
        end
    end

    // coincidence enable follows the next history
    always_ff @(posedge mclk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            coinc_q <= 1'b0;
        end
        else
        begin
            coinc_q <= all_same;
        end
    end

    // one-cycle strobe after each shift
    always_ff @(posedge mclk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            strobe_q <= 1'b0;
        end
        else
        begin
            strobe_q <= fall;
        end
    end

    // history known flag
    always_ff @(posedge mclk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            hist_valid_q <= 1'b0;
        end
        else
        begin
            hist_valid_q <= hist_known_d;
        end
    end

    // each output bit is offered to the capture fifo on the strobe, one cycle after its shift
    assign cap_s.valid = strobe_q;
    assign cap_s.data = FIFO_W'(out_q);

    // low ready means a strobed bit is dropped, not held
    assign capture_ready_o = cap_s.ready;

    sdbs_fifo #(
        .W(FIFO_W),
        .D(FIFO_D)
    ) u_fifo (
        .mclk_i(mclk_i),
        .rst_n_i(rst_n_i),
        .in_s(cap_s),
        .out_s(drn_s)
    );

    // drain side of the fifo
    assign stream_data_o = drn_s.data;
    assign stream_valid_o = drn_s.valid;
    assign drn_s.ready = stream_ready_i;

    // open collector coincidence: data fixed low, enable pulls the pin
    assign coinc_o = 1'b0;
    assign coinc_oe_o = coinc_q;

    // serial output and slope polarity pins
    assign data_out_o = out_q;
    assign slope_source_o = slope_q;

    // history view and shift strobe
    assign hist_o = hist_q;
    assign hist_valid_o = hist_valid_q;
    assign bit_strobe_o = strobe_q;
endmodule // sdbs_sequencer

// ---- verif/sdbs_seq_properties.sv ----
// port assertions for the sequencer
`timescale 1ns/1ps
module sdbs_seq_props (
    input wire logic mclk_i,
    input wire logic rst_n_i,
    input wire logic bit_clk_i,
    input wire logic encode_i,
    input wire logic ain_above_fb_i,
    input wire logic data_in_i,
    input wire logic data_out_o,
    input wire logic slope_source_o,
    input wire logic coinc_o,
    input wire logic coinc_oe_o,
    input wire logic [2:0] hist_o,
    input wire logic hist_valid_o,
    input wire logic bit_strobe_o,
    input wire logic capture_ready_o,
    input wire logic stream_valid_o
);
    default clocking @(posedge mclk_i); endclocking
    default disable iff (!rst_n_i);
    logic bc_q;
    wire fall = bc_q & ~bit_clk_i;
    wire sel = encode_i ? ain_above_fb_i : data_in_i;
    // previous bit clock level
    always_ff @(posedge mclk_i or negedge rst_n_i)
        if (!rst_n_i) bc_q <= 1'b0;
        else bc_q <= bit_clk_i;
    a_out_sel: assert property (fall |=> data_out_o == ~$past(sel))
        else $error("serial out wrong");
    a_slope_sel: assert property (fall |=> slope_source_o == $past(sel))
        else $error("slope wrong");
    a_hist_shift: assert property (fall |=> hist_o == {$past(hist_o[1:0]), $past(sel)})
        else $error("history shift wrong");
    a_out_holds: assert property (!fall |=> $stable(data_out_o) && $stable(hist_o))
        else $error("output moved off edge");
    a_strobe_cause: assert property (bit_strobe_o |-> $past(fall))
        else $error("strobe without edge");
    a_coinc_equal: assert property (bit_strobe_o |-> coinc_oe_o ==
        (hist_valid_o && (hist_o == 3'h7 || hist_o == 3'h0)))
        else $error("coincidence wrong");
    a_coinc_holds: assert property (!bit_strobe_o |-> $stable(coinc_oe_o))
        else $error("coincidence moved");
    a_pin_low: assert property (coinc_o == 1'b0)
        else $error("coincidence data not low");
    a_push_valid: assert property (bit_strobe_o && capture_ready_o |=> stream_valid_o)
        else $error("pushed bit not offered");
    c_enc: cover property (fall && encode_i);
    c_dec: cover property (fall && !encode_i);
    c_drop: cover property (bit_strobe_o && !capture_ready_o);
endmodule // sdbs_seq_props
bind sdbs_sequencer sdbs_seq_props u_props (.mclk_i(mclk_i), .rst_n_i(rst_n_i),
    .bit_clk_i(bit_clk_i), .encode_i(encode_i), .ain_above_fb_i(ain_above_fb_i),
    .data_in_i(data_in_i), .data_out_o(data_out_o), .slope_source_o(slope_source_o),
    .coinc_o(coinc_o), .coinc_oe_o(coinc_oe_o), .hist_o(hist_o), .hist_valid_o(hist_valid_o),
    .bit_strobe_o(bit_strobe_o), .capture_ready_o(capture_ready_o),
    .stream_valid_o(stream_valid_o));

// ---- verif/sdbs_chan_model.sv ----
// far-side serial channel: bit clock and data input
`timescale 1ns/1ps
module sdbs_chan_model (
    input wire logic mclk_i,
    input wire logic run_i,
    input wire logic loop_i,
    input wire logic rnd_i,
    input wire logic data_out_i,
    output logic bit_clk_o,
    output logic data_o
);
    int cnt = 0;
    logic pat_q = 1'b0;
    initial bit_clk_o = 1'b0;
    // one bit per 8-cycle period; clock stands still while stopped
    always @(posedge mclk_i)
        if (run_i)
        begin
            cnt <= (cnt == 7) ? 0 : cnt + 1;
            bit_clk_o <= (cnt < 4);
            if (cnt == 0) pat_q <= rnd_i;
        end
    // loopback returns the serial output as data input, giving the idle toggle pattern in decode
    assign data_o = loop_i ? data_out_i : pat_q;
endmodule // sdbs_chan_model

// ---- verif/testbench.sv ----
// self-checking bench for the slope delta bit sequencer
`timescale 1ns/1ps
module testbench;
    logic mclk_i = 1'b0;
    logic rst_n_i = 1'b0;
    logic encode_i = 1'b1;
    logic ain = 1'b0;
    logic rdy = 1'b1;
    logic rnd = 1'b0;
    logic bcq = 1'b0;
    logic es = 1'b0;
    logic [7:0] lf = 8'h31;
    logic [2:0] eh = 3'h0;
    logic bclk, din, dout, slope, coinc, coe, hval, stb, crdy, sdat, sval;
    logic [2:0] hist;
    logic q[$];
    int mode = 0;
    int fill = 0;
    int failures = 0;
    int checks_done = 0;
    sdbs_chan_model chan_u (.mclk_i(mclk_i), .run_i(mode != 2), .loop_i(mode == 3),
        .rnd_i(rnd), .data_out_i(dout), .bit_clk_o(bclk), .data_o(din));
    sdbs_sequencer dut_u (.mclk_i(mclk_i), .rst_n_i(rst_n_i), .bit_clk_i(bclk),
        .encode_i(encode_i), .ain_above_fb_i(ain), .data_in_i(din), .data_out_o(dout),
        .slope_source_o(slope), .coinc_o(coinc), .coinc_oe_o(coe), .hist_o(hist),
        .hist_valid_o(hval), .bit_strobe_o(stb), .capture_ready_o(crdy),
        .stream_data_o(sdat), .stream_valid_o(sval), .stream_ready_i(rdy));
    always #5 mclk_i = ~mclk_i;
    function automatic logic [7:0] lfsr(input logic [7:0] v);
        return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
    endfunction
    task automatic chk(input logic ok, input string m);
        checks_done++;
        if (ok !== 1'b1)
        begin
            failures++;
            $display("[FAIL] %0t %s", $time, m);
        end
    endtask
    task automatic tally_and_finish;
        $display("checks %0d failures %0d", checks_done, failures);
        if (failures == 0 && checks_done > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    // random drive, reference history and stream pops
    always @(posedge mclk_i)
    begin
        lf <= lfsr(lf);
        ain <= lf[0];
        rnd <= lf[1];
        rdy <= (mode == 0) ? lf[2] | lf[3] : (mode != 1);
        encode_i <= (mode == 3) ? 1'b0 : lf[4];
        if (bcq && !bclk)
        begin
            es = encode_i ? ain : din;
            eh = {eh[1:0], es};
            fill++;
        end
        bcq <= rst_n_i & bclk;
        if (sval && rdy) chk(q.size() > 0 && sdat === q.pop_front(), "stream word");
    end
    // checks one cycle after each shift
    always @(negedge mclk_i)
        if (stb)
        begin
            chk(dout === ~es && slope === es, "serial out");
            chk(hist === eh, "history");
            chk(coe === ((fill >= 3) && (eh == 3'h7 || eh == 3'h0)), "coinc");
            chk(hval === (fill >= 3) && coinc === 1'b0, "valid and pin");
            if (crdy) q.push_back(~es);
        end
    task automatic bits(input int n);
        repeat (n * 8) @(posedge mclk_i);
        @(negedge mclk_i);
    endtask
    initial
    begin
        repeat (10) @(posedge mclk_i);
        rst_n_i <= 1'b1;
        bits(120);
        $display("test random mix done");
        mode = 1;
        bits(8);
        chk(crdy === 1'b0 && q.size() == sdbs_pkg::FIFO_D, "fifo full");
        mode = 2;
        bits(4);
        chk(sval === 1'b0 && q.size() == 0, "fifo drained");
        $display("test fill and drain done");
        mode = 3;
        bits(20);
        $display("test loopback done");
        tally_and_finish();
    end
    initial
    begin
        #50us;
        failures++;
        tally_and_finish();
    end
endmodule // testbench
